// *** src/slcfg_bank.sv ***
/*
 * Link parameter register bank: eight byte registers holding the
 * receive link parameters, with field checks and readback.
 * Assumes a byte register port on the system clock, one request at a
 * time from the serial port engine, and a same-clock converter count
 * from the datapath mode logic.
 */
`timescale 1ns/1ps
`default_nettype none

module slcfg_bank
   import slcfg_pkg::*;
(
   input wire logic SYS_CLK_I,          // 100 MHz system clock
   input wire logic RST_I,              // sync reset, high
   input wire slcfg_req_t REQ_I,        // register request
   input wire logic [2:0] CONV_COUNT_I, // active converters, 1/2/4
   input wire logic DUAL_LINK_I,        // dual link mode
   output slcfg_rsp_t RSP_O,            // read answer
   output slcfg_params_t PARAMS_O,      // stored parameters
   output logic LANES_OK_O,             // lane count legal for mode
   output logic CONV_OK_O,              // converter count legal
   output logic MF_OK_O,                // multiframe length legal
   output logic [7:0] PARAM_SUM_O       // parameter byte sum
);

   typedef struct packed {
      slcfg_params_t params;
      slcfg_rsp_t rsp;
   } slcfg_state_t;

   slcfg_state_t state;
   slcfg_state_t next_state;
   logic [7:0] conv_req_code;
   logic conv_req_ok;

   // converter count from the mode logic, encoded as count minus one
   always_comb begin
      conv_req_code = CONV_1;
      conv_req_ok = 1'b1;
      unique case (CONV_COUNT_I)
         3'h1: conv_req_code = CONV_1;
         3'h2: conv_req_code = CONV_2;
         3'h4: conv_req_code = CONV_4;
         default: conv_req_ok = 1'b0;
      endcase
      if (DUAL_LINK_I && (conv_req_code == CONV_4)) begin
         conv_req_ok = 1'b0;
      end
   end

   // register writes, readback and converter count tracking
   always_comb begin
      next_state = state;
      next_state.rsp.valid = 1'b0;
      next_state.rsp.hit = 1'b0;
      next_state.rsp.data = 8'h00;
      // illegal counts keep the last legal code rather than a garbage one
      if (conv_req_ok) begin
         next_state.params.conv_code = conv_req_code;
      end
      if (REQ_I.wr) begin
         unique case (REQ_I.addr)
            ADDR_SCR_LANES: begin
               next_state.params.descramble = REQ_I.wdata[TOP_BIT];
               next_state.params.lanes = REQ_I.wdata[LOW_MSB:0];
            end
            ADDR_FRAME_OCT: begin
               next_state.params.frame_octets = REQ_I.wdata;
            end
            ADDR_MF_LEN: begin
               if (REQ_I.wdata[LOW_MSB:0] inside {MF_16, MF_32}) begin
                  next_state.params.mf_len = REQ_I.wdata[LOW_MSB:0];
               end
            end
            ADDR_CS_RES: begin
               next_state.params.ctrl_bits = REQ_I.wdata[TOP_BIT:CS_LSB];
               next_state.params.resolution = REQ_I.wdata[LOW_MSB:0];
            end
            ADDR_SUBCL_NP: begin
               next_state.params.subclass = REQ_I.wdata[TOP_BIT:UPPER_LSB];
               next_state.params.sample_bits = REQ_I.wdata[LOW_MSB:0];
            end
            ADDR_REV_S: begin
               next_state.params.revision =
                  REQ_I.wdata[TOP_BIT:UPPER_LSB];
               if (REQ_I.wdata[LOW_MSB:0] inside {SAMP_ONE, SAMP_TWO}) begin
                  next_state.params.samples =
                     REQ_I.wdata[LOW_MSB:0];
               end
            end
            ADDR_HD_CF: begin
               next_state.params.high_density =
                  REQ_I.wdata[TOP_BIT];
               next_state.params.ctrl_words = REQ_I.wdata[LOW_MSB:0];
            end
            default: begin
               // converter count and unmapped offsets ignore writes
               next_state.params = next_state.params;
            end
         endcase
      end
      // reads see the value held before this cycle's write
      if (REQ_I.rd) begin
         next_state.rsp.valid = 1'b1;
         next_state.rsp.hit = slcfg_mapped(REQ_I.addr);
         next_state.rsp.data = slcfg_read_byte(state.params,
            REQ_I.addr);
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         state.params <= PARAMS_RESET;
         state.rsp <= '0;
      end else begin
         state <= next_state;
      end
   end

   slcfg_mode_check u_check (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .params_i(state.params),
      .dual_link_i(DUAL_LINK_I),
      .lanes_ok_o(LANES_OK_O),
      .conv_ok_o(CONV_OK_O),
      .mf_ok_o(MF_OK_O)
   );

   slcfg_param_sum u_sum (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .params_i(state.params),
      .sum_o(PARAM_SUM_O)
   );

   assign RSP_O = state.rsp;
   assign PARAMS_O = state.params;

   // checks on the bank's own behaviour
   scr_write_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      REQ_I.wr && REQ_I.addr == ADDR_SCR_LANES |=>
      PARAMS_O.descramble == $past(REQ_I.wdata[7]))
      else $error("descramble bit did not follow write");

   scr_reset_a: assert property (@(posedge SYS_CLK_I)
      $fell(RST_I) |-> PARAMS_O.descramble && PARAMS_O.lanes == 5'h03 &&
      PARAMS_O.high_density && PARAMS_O.revision == 3'h1)
      else $error("reset values wrong after reset");

   lanes_write_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      REQ_I.wr && REQ_I.addr == ADDR_SCR_LANES ##1 REQ_I.rd &&
      REQ_I.addr == ADDR_SCR_LANES && !REQ_I.wr |=>
      RSP_O.data[4:0] == $past(REQ_I.wdata[4:0], 2) && RSP_O.data[6:5] == 2'h0)
      else $error("lane field readback wrong");

   mf_guard_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      REQ_I.wr && REQ_I.addr == ADDR_MF_LEN &&
      !(REQ_I.wdata[4:0] inside {5'h0f, 5'h1f}) |=> $stable(PARAMS_O.mf_len))
      else $error("illegal multiframe length stored");

   mf_legal_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      PARAMS_O.mf_len == 5'h0f || PARAMS_O.mf_len == 5'h1f)
      else $error("multiframe length holds illegal code");

   samp_guard_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      REQ_I.wr && REQ_I.addr == ADDR_REV_S && REQ_I.wdata[4:1] != 4'h0
      |=> $stable(PARAMS_O.samples) &&
      PARAMS_O.revision == $past(REQ_I.wdata[7:5]))
      else $error("samples field accepted illegal code");

   conv_ro_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      REQ_I.wr && REQ_I.addr == ADDR_CONV_CNT && !conv_req_ok
      |=> $stable(PARAMS_O.conv_code))
      else $error("converter count changed by write");

   conv_code_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      CONV_COUNT_I == 3'h4 && !DUAL_LINK_I |=> PARAMS_O.conv_code == 8'h03)
      else $error("four converters not coded as 3");

   rsvd_zero_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      RSP_O.valid && !RSP_O.hit |-> RSP_O.data == 8'h00)
      else $error("unmapped read returned data");

   read_time_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      REQ_I.rd |=> RSP_O.valid ##1 !RSP_O.valid || $past(REQ_I.rd))
      else $error("read answer not one cycle pulse");

   frame_store_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      REQ_I.wr && REQ_I.addr == ADDR_FRAME_OCT |=>
      PARAMS_O.frame_octets == $past(REQ_I.wdata))
      else $error("frame octets not stored");

   // field stores, refusals and reserved bits seen from outside; each
   // is tripped by all-ones writes or by the edge codes of the fields
   fld_reset_a: assert property (
      @(posedge SYS_CLK_I)
      $fell(RST_I) |-> PARAMS_O.frame_octets == 8'h00 &&
      PARAMS_O.mf_len == 5'h1f && PARAMS_O.conv_code == 8'h01 &&
      PARAMS_O.samples == 5'h00 && PARAMS_O.ctrl_words == 5'h00)
      else $error("field reset values wrong after reset");

   lanes_store_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      REQ_I.wr && REQ_I.addr == ADDR_SCR_LANES |=>
      PARAMS_O.lanes == $past(REQ_I.wdata[4:0]))
      else $error("lane field did not follow write");

   mf_accept_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      REQ_I.wr && REQ_I.addr == ADDR_MF_LEN &&
      REQ_I.wdata[4:0] inside {5'h0f, 5'h1f} |=>
      PARAMS_O.mf_len == $past(REQ_I.wdata[4:0]))
      else $error("legal multiframe length not stored");

   conv_write_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      REQ_I.wr && REQ_I.addr == ADDR_CONV_CNT |=>
      PARAMS_O.conv_code inside {8'h00, 8'h01, 8'h03})
      else $error("write reached converter count");

   conv_legal_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      PARAMS_O.conv_code inside {8'h00, 8'h01, 8'h03})
      else $error("converter count holds illegal code");

   conv_hold_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      !(CONV_COUNT_I inside {3'h1, 3'h2, 3'h4}) ||
      (DUAL_LINK_I && CONV_COUNT_I == 3'h4) |=>
      $stable(PARAMS_O.conv_code))
      else $error("refused converter count was stored");

   samp_accept_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      REQ_I.wr && REQ_I.addr == ADDR_REV_S && REQ_I.wdata[4:1] == 4'h0
      |=> PARAMS_O.samples == $past(REQ_I.wdata[4:0]))
      else $error("legal samples code not stored");

   rev_store_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      REQ_I.wr && REQ_I.addr == ADDR_REV_S |=>
      PARAMS_O.revision == $past(REQ_I.wdata[7:5]))
      else $error("revision field did not follow write");

   hd_write_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      REQ_I.wr && REQ_I.addr == ADDR_HD_CF |=>
      PARAMS_O.high_density == $past(REQ_I.wdata[7]))
      else $error("density flag did not follow write");

   read_hit_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      RSP_O.valid |-> RSP_O.hit ==
      ($past(REQ_I.addr) inside {[ADDR_SCR_LANES:ADDR_HD_CF]}))
      else $error("read hit does not match the offset");

   rsp_idle_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      !$past(REQ_I.rd) |-> !RSP_O.valid && !RSP_O.hit &&
      RSP_O.data == 8'h00)
      else $error("read answer without a read");

   rsvd_scr_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      RSP_O.valid && $past(REQ_I.addr) == ADDR_SCR_LANES |->
      RSP_O.data[6:5] == 2'h0)
      else $error("scramble register reserved bits set");

   rsvd_mf_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      RSP_O.valid && $past(REQ_I.addr) == ADDR_MF_LEN |->
      RSP_O.data[7:5] == 3'h0)
      else $error("multiframe register reserved bits set");

   rsvd_res_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      RSP_O.valid && $past(REQ_I.addr) == ADDR_CS_RES |->
      RSP_O.data[5] == 1'b0)
      else $error("resolution register reserved bit set");

   rsvd_hd_a: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      RSP_O.valid && $past(REQ_I.addr) == ADDR_HD_CF |->
      RSP_O.data[6:5] == 2'h0)
      else $error("density register reserved bits set");

endmodule : slcfg_bank
`default_nettype wire

// *** include/slcfg_pkg.sv ***
/*
 * Shared definitions for the serial link parameter bank: register
 * offsets, field positions, reset values, carrier structs and the
 * byte readback function used by the bank and by the sum logic.
 * Assumes a byte-wide register port with a 12-bit address.
 */
`default_nettype none
package slcfg_pkg;

   // register offsets
   localparam logic [11:0] ADDR_SCR_LANES = 12'h453;
   localparam logic [11:0] ADDR_FRAME_OCT = 12'h454;
   localparam logic [11:0] ADDR_MF_LEN = 12'h455;
   localparam logic [11:0] ADDR_CONV_CNT = 12'h456;
   localparam logic [11:0] ADDR_CS_RES = 12'h457;
   localparam logic [11:0] ADDR_SUBCL_NP = 12'h458;
   localparam logic [11:0] ADDR_REV_S = 12'h459;
   localparam logic [11:0] ADDR_HD_CF = 12'h45a;
   localparam int NUM_REGS = 8;

   // field positions
   localparam int TOP_BIT = 7;
   localparam int UPPER_LSB = 5;
   localparam int CS_LSB = 6;
   localparam int LOW_MSB = 4;

   // accepted encodings
   localparam logic [4:0] MF_16 = 5'h0f;
   localparam logic [4:0] MF_32 = 5'h1f;
   localparam logic [4:0] SAMP_ONE = 5'h00;
   localparam logic [4:0] SAMP_TWO = 5'h01;
   localparam logic [4:0] LANES_1 = 5'h00;
   localparam logic [4:0] LANES_2 = 5'h01;
   localparam logic [4:0] LANES_4 = 5'h03;
   localparam logic [4:0] LANES_8 = 5'h07;
   localparam logic [7:0] CONV_1 = 8'h00;
   localparam logic [7:0] CONV_2 = 8'h01;
   localparam logic [7:0] CONV_4 = 8'h03;
   localparam logic [7:0] FRAME_4OCT = 8'h03;

   typedef struct packed {
      logic descramble;
      logic [4:0] lanes;
      logic [7:0] frame_octets;
      logic [4:0] mf_len;
      logic [7:0] conv_code;
      logic [1:0] ctrl_bits;
      logic [4:0] resolution;
      logic [2:0] subclass;
      logic [4:0] sample_bits;
      logic [2:0] revision;
      logic [4:0] samples;
      logic high_density;
      logic [4:0] ctrl_words;
   } slcfg_params_t;

   // reset values
   localparam slcfg_params_t PARAMS_RESET = '{
      descramble: 1'h1, lanes: 5'h03, frame_octets: 8'h00,
      mf_len: 5'h1f, conv_code: 8'h01, ctrl_bits: 2'h0,
      resolution: 5'h1f, subclass: 3'h1, sample_bits: 5'h0f,
      revision: 3'h1, samples: 5'h00, high_density: 1'h1,
      ctrl_words: 5'h00};

   typedef struct packed {
      logic [11:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } slcfg_req_t;

   typedef struct packed {
      logic [7:0] data;
      logic valid;
      logic hit;
   } slcfg_rsp_t;

   // reserved bits are filled with zero here
   function automatic logic [7:0] slcfg_read_byte(
         input slcfg_params_t p, input logic [11:0] addr);
      logic [7:0] b;
      b = 8'h00;
      unique case (addr)
         ADDR_SCR_LANES: b = {p.descramble, 2'h0, p.lanes};
         ADDR_FRAME_OCT: b = p.frame_octets;
         ADDR_MF_LEN: b = {3'h0, p.mf_len};
         ADDR_CONV_CNT: b = p.conv_code;
         ADDR_CS_RES: b = {p.ctrl_bits, 1'h0, p.resolution};
         ADDR_SUBCL_NP: b = {p.subclass, p.sample_bits};
         ADDR_REV_S: b = {p.revision, p.samples};
         ADDR_HD_CF: b = {p.high_density, 2'h0, p.ctrl_words};
         default: b = 8'h00;
      endcase
      return b;
   endfunction : slcfg_read_byte

   function automatic logic slcfg_mapped(input logic [11:0] addr);
      return (addr >= ADDR_SCR_LANES) && (addr <= ADDR_HD_CF);
   endfunction : slcfg_mapped

endpackage : slcfg_pkg
`default_nettype wire

// *** src/slcfg_mode_check.sv ***
/*
 * Registered plausibility flags for the programmed link parameters
 * against single or dual link mode. Assumes same-clock inputs.
 */
`timescale 1ns/1ps
`default_nettype none
module slcfg_mode_check
   import slcfg_pkg::*;
(
   input wire logic clk_i,              // system clock
   input wire logic rst_i,              // sync reset, high
   input wire slcfg_params_t params_i,  // current parameters
   input wire logic dual_link_i,        // dual link mode
   output logic lanes_ok_o,             // lane count legal
   output logic conv_ok_o,              // converter count legal
   output logic mf_ok_o                 // multiframe length legal
);

   typedef struct packed {
      logic lanes_ok;
      logic conv_ok;
      logic mf_ok;
   } slcfg_chk_t;

   slcfg_chk_t state;
   slcfg_chk_t next_state;

   // flags only report; software owns legal programming
   always_comb begin
      next_state.lanes_ok = dual_link_i ?
         (params_i.lanes inside {LANES_1, LANES_2, LANES_4}) :
         (params_i.lanes inside {LANES_2, LANES_4, LANES_8});
      next_state.conv_ok = dual_link_i ?
         (params_i.conv_code inside {CONV_1, CONV_2}) :
         (params_i.conv_code inside {CONV_1, CONV_2, CONV_4});
      next_state.mf_ok = (params_i.frame_octets != FRAME_4OCT) ||
         (params_i.mf_len == MF_32);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign lanes_ok_o = state.lanes_ok;
   assign conv_ok_o = state.conv_ok;
   assign mf_ok_o = state.mf_ok;

endmodule : slcfg_mode_check
`default_nettype wire

// *** src/slcfg_param_sum.sv ***
/*
 * Running byte sum, modulo 256, of the parameter registers this bank
 * holds, for software to compare against its own checksum.
 */
`timescale 1ns/1ps
`default_nettype none
module slcfg_param_sum
   import slcfg_pkg::*;
(
   input wire logic clk_i,              // system clock
   input wire logic rst_i,              // sync reset, high
   input wire slcfg_params_t params_i,  // current parameters
   output logic [7:0] sum_o             // sum modulo 256
);

   typedef struct packed {
      logic [7:0] sum;
   } slcfg_sum_t;

   slcfg_sum_t state;
   slcfg_sum_t next_state;

   // eight-bit accumulator wraps, giving modulo 256 for free
   always_comb begin
      next_state.sum = 8'h00;
      for (int i = 0; i < NUM_REGS; i++) begin
         next_state.sum = next_state.sum + slcfg_read_byte(params_i,
            ADDR_SCR_LANES + 12'(i));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign sum_o = state.sum;

endmodule : slcfg_param_sum
`default_nettype wire

// *** tb/slcfg_bank_tb.sv ***
/*
 * Self-checking bench for the link parameter bank: reset values,
 * masked writes, refused codes, converter tracking, flags and sum.
 * Assumes the bank's one-cycle read answer and registered flags.
 */
`timescale 1ns/1ps
`default_nettype none
module slcfg_bank_tb
   import slcfg_pkg::*;
   ;

   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   slcfg_req_t req = '0;
   logic [2:0] conv_count = 3'h2;
   logic dual_link = 1'b0;
   slcfg_rsp_t rsp;
   slcfg_params_t params;
   logic lanes_ok;
   logic conv_ok;
   logic mf_ok;
   logic [7:0] param_sum;
   int fail_count = 0;
   int check_count = 0;
   logic [7:0] exp_reg [NUM_REGS];

   slcfg_bank slcfg_bank_i (
      .SYS_CLK_I(sys_clk),
      .RST_I(rst),
      .REQ_I(req),
      .CONV_COUNT_I(conv_count),
      .DUAL_LINK_I(dual_link),
      .RSP_O(rsp),
      .PARAMS_O(params),
      .LANES_OK_O(lanes_ok),
      .CONV_OK_O(conv_ok),
      .MF_OK_O(mf_ok),
      .PARAM_SUM_O(param_sum)
   );

   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
         input string what);
      check_count++;
      if (got !== exp) begin
         $display("unexpected at %0t: %s got %h exp %h", $time, what,
            got, exp);
         fail_count++;
      end
   endtask : chk

   task automatic print_verdict();
      if (fail_count == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   // all requests launched 1 ns after the edge
   task automatic wr(input logic [11:0] addr, input logic [7:0] data);
      req.addr = addr;
      req.wdata = data;
      req.wr = 1'b1;
      @(posedge sys_clk);
      #1 req.wr = 1'b0;
      // idle edge, so a following call never re-raises in this step
      @(posedge sys_clk);
      #1;
   endtask : wr

   task automatic rd(input logic [11:0] addr, input logic [7:0] exp,
         input logic hit);
      req.addr = addr;
      req.rd = 1'b1;
      @(posedge sys_clk);
      #1 req.rd = 1'b0;
      chk({7'h0, rsp.valid}, 8'h01, "read valid");
      chk({7'h0, rsp.hit}, {7'h0, hit}, "read hit");
      chk(rsp.data, exp, "read data");
      @(posedge sys_clk);
      #1;
      chk({7'h0, rsp.valid}, 8'h00, "valid one cycle");
   endtask : rd

   task automatic settle();
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : settle

   // reads every register and the sum against the bench's own image
   task automatic check_all();
      logic [7:0] sum;
      sum = 8'h00;
      for (int i = 0; i < NUM_REGS; i++) begin
         rd(ADDR_SCR_LANES + 12'(i), exp_reg[i], 1'b1);
         sum = sum + exp_reg[i];
      end
      settle();
      chk({7'h0, rsp.valid}, 8'h00, "valid one cycle");
      chk(param_sum, sum, "byte sum");
   endtask : check_all

   task automatic do_reset();
      rst = 1'b1;
      repeat (8) @(posedge sys_clk);
      #1 rst = 1'b0;
      exp_reg = '{8'h83, 8'h00, 8'h1f, 8'h01, 8'h1f, 8'h2f, 8'h20,
         8'h80};
      settle();
   endtask : do_reset

   // watchdog, far beyond the expected run
   initial begin
      repeat (5000) @(posedge sys_clk);
      fail_count++;
      print_verdict();
   end

   initial begin
      logic [2:0] cnt_tab [5];
      logic dual_tab [5];
      logic [7:0] code_tab [5];
      logic ok_tab [5];
      cnt_tab = '{3'h4, 3'h4, 3'h1, 3'h2, 3'h3};
      dual_tab = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
      code_tab = '{8'h03, 8'h03, 8'h00, 8'h01, 8'h01};
      ok_tab = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
      #1;
      do_reset();
      check_all();
      chk({7'h0, params.descramble}, 8'h01, "descramble reset");
      chk({7'h0, params.high_density}, 8'h01, "density reset");
      // all ones into every byte: reserved bits and read-only stay
      for (int i = 0; i < NUM_REGS; i++) begin
         wr(ADDR_SCR_LANES + 12'(i), 8'hff);
      end
      exp_reg = '{8'h9f, 8'hff, 8'h1f, 8'h01, 8'hdf, 8'hff, 8'he0,
         8'h9f};
      check_all();
      // multiframe length: 16 taken, odd code refused
      wr(ADDR_MF_LEN, 8'h0f);
      wr(ADDR_MF_LEN, 8'h10);
      rd(ADDR_MF_LEN, 8'h0f, 1'b1);
      exp_reg[2] = 8'h0f;
      // samples: two taken, three refused while revision still stores
      wr(ADDR_REV_S, 8'h01);
      wr(ADDR_REV_S, 8'h02);
      rd(ADDR_REV_S, 8'h01, 1'b1);
      exp_reg[6] = 8'h01;
      // frame octets: same-cycle read returns the old byte
      req = '{addr: ADDR_FRAME_OCT, wr: 1'b1, rd: 1'b1, wdata: 8'ha5};
      @(posedge sys_clk);
      #1 req = '0;
      chk(rsp.data, 8'hff, "read beside write");
      @(posedge sys_clk);
      #1;
      rd(ADDR_FRAME_OCT, 8'ha5, 1'b1);
      exp_reg[1] = 8'ha5;
      // descramble off, eight lanes, then one lane in both modes
      wr(ADDR_SCR_LANES, 8'h07);
      rd(ADDR_SCR_LANES, 8'h07, 1'b1);
      chk({7'h0, params.descramble}, 8'h00, "descramble off");
      chk({3'h0, params.lanes}, 8'h07, "eight lanes");
      settle();
      chk({7'h0, lanes_ok}, 8'h01, "eight lanes single");
      wr(ADDR_SCR_LANES, 8'h80);
      settle();
      chk({7'h0, lanes_ok}, 8'h00, "one lane single");
      dual_link = 1'b1;
      settle();
      chk({7'h0, lanes_ok}, 8'h01, "one lane dual");
      exp_reg[0] = 8'h80;
      // converter count follows the mode logic, four refused in dual
      for (int i = 0; i < 5; i++) begin
         dual_link = dual_tab[i];
         conv_count = cnt_tab[i];
         settle();
         wr(ADDR_CONV_CNT, 8'hff);
         chk({7'h0, conv_ok}, {7'h0, ok_tab[i]}, "conv legal");
         rd(ADDR_CONV_CNT, code_tab[i], 1'b1);
      end
      exp_reg[3] = 8'h01;
      // four-octet frames need the 32-frame multiframe
      wr(ADDR_FRAME_OCT, FRAME_4OCT);
      settle();
      chk({7'h0, mf_ok}, 8'h00, "four octets at 16");
      wr(ADDR_MF_LEN, 8'h1f);
      settle();
      chk({7'h0, mf_ok}, 8'h01, "four octets at 32");
      exp_reg[1] = FRAME_4OCT;
      exp_reg[2] = 8'h1f;
      // outside the bank: no hit, zero data, writes dropped
      wr(12'h45b, 8'h55);
      rd(12'h452, 8'h00, 1'b0);
      rd(12'h45b, 8'h00, 1'b0);
      check_all();
      // second reset restores every field
      do_reset();
      check_all();
      print_verdict();
   end

endmodule : slcfg_bank_tb
`default_nettype wire
